// ===== core/dmc_pkg.sv
package dmc_pkg;
   // AXI byte address width; a register's byte address is four times its index.
   localparam int AW = 9;
   // Register indices within one channel; the channel number sits in index bits 6:5.
   localparam logic [4:0] OFS_A_CNT = 5'h00;
   localparam logic [4:0] OFS_A_RLD = 5'h04;
   localparam logic [4:0] OFS_B_CNT = 5'h08;
   localparam logic [4:0] OFS_B_RLD = 5'h0C;
   localparam logic [4:0] OFS_LEN_CNT = 5'h10;
   localparam logic [4:0] OFS_LEN_RLD = 5'h14;
   localparam logic [4:0] OFS_CTL = 5'h1C;
   localparam logic [4:0] OFS_STAT = 5'h1E;
   localparam logic [16:0] CTL_RST = 17'h0_0000;
   localparam logic [3:0] STAT_RST = 4'h0;
   localparam logic [23:0] ADDR_RST = 24'h00_0000;
   localparam logic [15:0] LEN_RST = 16'h0000;
   localparam logic [15:0] LEN_ONE = 16'h0001;
   localparam logic [23:0] STEP_ONE = 24'h00_0001;
   localparam logic [23:0] STEP_TWO = 24'h00_0002;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic swrq;
      logic sec_en;
      logic pri_en;
      logic ovr_ie;
      logic tc_ie;
      logic [1:0] side_b_step_size;
      logic [1:0] side_a_step_size;
      logic adb;
      logic ada;
      logic auto_rl;
      logic cont;
      logic indirect;
      logic wide;
      logic dir;
      logic en;
   } dmc_ctl_t;

   typedef struct packed {
      logic vld;
      logic channel_active_flag;
      logic overrun_flag;
      logic tc;
   } dmc_stat_t;

   // One system bus cycle as driven by the controller.
   typedef struct packed {
      logic [23:0] addr;
      logic rd;
      logic wr;
      logic wide;
      logic drive;
   } dmc_sys_t;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_ARB = 2'b01,
      S_XF = 2'b10,
      S_WR = 2'b11
   } dmc_state_t;
endpackage : dmc_pkg

// ===== core/dmc_top.sv
`timescale 1ns/1ps
module dmc_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [dmc_pkg::AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [dmc_pkg::AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic req_serial_rx,
   input wire logic req_serial_tx,
   input wire logic req_audio_rx,
   input wire logic req_transcoder_out,
   input wire logic req_audio_tx,
   input wire logic req_transcoder_in,
   output logic bus_req,
   input wire logic bus_grant,
   output dmc_pkg::dmc_sys_t sys_cyc,
   output logic [15:0] sys_wdata,
   input wire logic [15:0] sys_rdata,
   output logic [3:0] ack,
   output logic [3:0] irq
);
   localparam int NCH = 4;

   dmc_pkg::dmc_ctl_t ctl_q [NCH];
   dmc_pkg::dmc_stat_t stat_q [NCH];
   logic [23:0] a_cnt_q [NCH];
   logic [23:0] a_rld_q [NCH];
   logic [23:0] b_cnt_q [NCH];
   logic [23:0] b_rld_q [NCH];
   logic [15:0] len_q [NCH];
   logic [15:0] len_rld_q [NCH];
   dmc_pkg::dmc_state_t st_q;
   logic [1:0] cur_q;

   function automatic logic [23:0] step(input logic [23:0] a, input logic en, input logic [1:0] f);
      logic [23:0] d;
      d = f[0] ? dmc_pkg::STEP_TWO : dmc_pkg::STEP_ONE;
      if (!en)
         step = a;
      else if (f[1])
         step = a - d;
      else
         step = a + d;
   endfunction : step

   // Bit 32 flags a mapped register; reserved bits read as zero.
   function automatic logic [32:0] reg_read(input logic [6:0] ix);
      logic [1:0] c;
      c = ix[6:5];
      case (ix[4:0])
         dmc_pkg::OFS_A_CNT: reg_read = {9'h100, a_cnt_q[c]};
         dmc_pkg::OFS_A_RLD: reg_read = {9'h100, a_rld_q[c]};
         dmc_pkg::OFS_B_CNT: reg_read = {9'h100, b_cnt_q[c]};
         dmc_pkg::OFS_B_RLD: reg_read = {9'h100, b_rld_q[c]};
         dmc_pkg::OFS_LEN_CNT: reg_read = {17'h1_0000, len_q[c]};
         dmc_pkg::OFS_LEN_RLD: reg_read = {17'h1_0000, len_rld_q[c]};
         dmc_pkg::OFS_CTL: reg_read = {16'h8000, ctl_q[c]};
         dmc_pkg::OFS_STAT: reg_read = {29'h1000_0000, stat_q[c]};
         default: reg_read = 33'h0_0000_0000;
      endcase
   endfunction : reg_read

   wire [3:0] hw_req;
   assign hw_req[0] = ctl_q[0].sec_en & req_serial_rx;
   assign hw_req[1] = ctl_q[1].pri_en & req_serial_tx;
   assign hw_req[2] = (ctl_q[2].pri_en & req_audio_rx) | (ctl_q[2].sec_en & req_transcoder_out);
   assign hw_req[3] = (ctl_q[3].pri_en & req_audio_tx) | (ctl_q[3].sec_en & req_transcoder_in);

   logic [3:0] req_c;
   for (genvar g = 0; g < NCH; g++)
   begin : g_req
      assign req_c[g] = ctl_q[g].en & stat_q[g].channel_active_flag & (hw_req[g] | ctl_q[g].swrq);
   end

   wire [1:0] pick = req_c[0] ? 2'h0 : req_c[1] ? 2'h1 : req_c[2] ? 2'h2 : 2'h3;

   dmc_pkg::dmc_ctl_t cc;
   assign cc = ctl_q[cur_q];
   wire [15:0] cur_len = len_q[cur_q];
   wire [23:0] a_nx = step(a_cnt_q[cur_q], cc.ada, cc.side_a_step_size);
   wire [23:0] b_nx = step(b_cnt_q[cur_q], cc.adb, cc.side_b_step_size);
   wire in_xf = st_q == dmc_pkg::S_XF;
   wire item_done = (in_xf && !cc.indirect) || st_q == dmc_pkg::S_WR;
   wire blk_end = item_done && cur_len <= dmc_pkg::LEN_ONE;
   // Request is looked at in the cycle the acknowledge drops.
   wire cont_go = item_done && !blk_end && cc.cont && req_c[cur_q];
   wire first = st_q == dmc_pkg::S_ARB && bus_grant && |req_c;
   wire do_issue = first || cont_go;
   wire do_second = in_xf && cc.indirect;
   wire do_stop = item_done && !cont_go;
   wire [1:0] ic = first ? pick : cur_q;
   dmc_pkg::dmc_ctl_t ictl;
   assign ictl = ctl_q[ic];
   wire [23:0] ia = first ? a_cnt_q[pick] : a_nx;
   wire [23:0] ib = first ? b_cnt_q[pick] : b_nx;
   wire [23:0] iss_addr = (ictl.indirect && ictl.dir) ? ib : ia;
   wire iss_rd = ictl.indirect | ~ictl.dir;
   wire iss_wr = ~ictl.indirect & ictl.dir;
   wire [3:0] iss_bit = 4'h1 << ic;
   wire [3:0] cur_bit = 4'h1 << cur_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_q <= dmc_pkg::S_IDLE;
         cur_q <= 2'h0;
         bus_req <= 1'b0;
         sys_cyc <= '0;
         sys_wdata <= 16'h0000;
         ack <= 4'h0;
      end
      else if (do_issue)
      begin
         // Direct cycles move data between the two ends without capture.
         sys_cyc <= '{addr: iss_addr, rd: iss_rd, wr: iss_wr, wide: ictl.wide, drive: 1'b0};
         ack <= (ictl.indirect && ictl.dir) ? 4'h0 : iss_bit;
         cur_q <= ic;
         st_q <= dmc_pkg::S_XF;
      end
      else if (do_second)
      begin
         sys_cyc <= '{addr: cc.dir ? a_cnt_q[cur_q] : b_cnt_q[cur_q], rd: 1'b0, wr: 1'b1, wide: cc.wide, drive: 1'b1};
         sys_wdata <= sys_rdata;
         ack <= cc.dir ? cur_bit : 4'h0;
         st_q <= dmc_pkg::S_WR;
      end
      else if (do_stop)
      begin
         sys_cyc <= '0;
         ack <= 4'h0;
         bus_req <= 1'b0;
         st_q <= dmc_pkg::S_IDLE;
      end
      else if (st_q == dmc_pkg::S_IDLE && |req_c)
      begin
         bus_req <= 1'b1;
         st_q <= dmc_pkg::S_ARB;
      end
      else if (st_q == dmc_pkg::S_ARB && !(|req_c))
      begin
         bus_req <= 1'b0;
         st_q <= dmc_pkg::S_IDLE;
      end
   end

   wire [6:0] w_idx = awaddr[8:2];
   wire [6:0] r_idx = araddr[8:2];
   wire [1:0] w_ch = w_idx[6:5];
   wire [4:0] w_ofs = w_idx[4:0];
   wire [32:0] w_look = reg_read(w_idx);
   wire [32:0] r_look = reg_read(r_idx);
   wire [31:0] wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
   wire [31:0] wval = (w_look[31:0] & ~wmask) | (wdata & wmask);
   wire aw_take = !awready && !bvalid && awvalid && wvalid;
   wire aw_hs = awvalid && awready && wvalid && wready;
   wire ar_hs = arvalid && arready;
   wire wr_go = aw_hs && w_look[32];
   wire [3:0] w_sel = wr_go ? (4'h1 << w_ch) : 4'h0;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= dmc_pkg::RESP_OKAY;
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= dmc_pkg::RESP_OKAY;
      end
      else
      begin
         awready <= aw_take;
         wready <= aw_take;
         arready <= !arready && !rvalid && arvalid;
         if (aw_hs)
         begin
            bvalid <= 1'b1;
            bresp <= w_look[32] ? dmc_pkg::RESP_OKAY : dmc_pkg::RESP_SLVERR;
         end
         else if (bready)
            bvalid <= 1'b0;
         if (ar_hs)
         begin
            rvalid <= 1'b1;
            rdata <= r_look[31:0];
            rresp <= r_look[32] ? dmc_pkg::RESP_OKAY : dmc_pkg::RESP_SLVERR;
         end
         else if (rready)
            rvalid <= 1'b0;
      end
   end

   // Software writes come first; the engine then overrides, and flag sets come last so they win.
   always_ff @(posedge aclk)
   begin
      for (int n = 0; n < NCH; n++)
      begin
         if (!aresetn)
         begin
            ctl_q[n] <= dmc_pkg::CTL_RST;
            stat_q[n] <= dmc_pkg::STAT_RST;
            a_cnt_q[n] <= dmc_pkg::ADDR_RST;
            a_rld_q[n] <= dmc_pkg::ADDR_RST;
            b_cnt_q[n] <= dmc_pkg::ADDR_RST;
            b_rld_q[n] <= dmc_pkg::ADDR_RST;
            len_q[n] <= dmc_pkg::LEN_RST;
            len_rld_q[n] <= dmc_pkg::LEN_RST;
            irq[n] <= 1'b0;
         end
         else
         begin
            if (w_sel[n] && w_ofs == dmc_pkg::OFS_A_CNT)
               a_cnt_q[n] <= wval[23:0];
            if (w_sel[n] && w_ofs == dmc_pkg::OFS_A_RLD)
               a_rld_q[n] <= wval[23:0];
            if (w_sel[n] && w_ofs == dmc_pkg::OFS_B_CNT)
               b_cnt_q[n] <= wval[23:0];
            if (w_sel[n] && w_ofs == dmc_pkg::OFS_B_RLD)
               b_rld_q[n] <= wval[23:0];
            if (w_sel[n] && w_ofs == dmc_pkg::OFS_LEN_CNT)
               len_q[n] <= wval[15:0];
            if (w_sel[n] && w_ofs == dmc_pkg::OFS_LEN_RLD)
               len_rld_q[n] <= wval[15:0];
            if (w_sel[n] && w_ofs == dmc_pkg::OFS_CTL)
            begin
               ctl_q[n] <= wval[16:0];
               stat_q[n].channel_active_flag <= wval[0];
            end
            if (w_sel[n] && w_ofs == dmc_pkg::OFS_STAT)
            begin
               stat_q[n].tc <= stat_q[n].tc & ~wval[0];
               stat_q[n].overrun_flag <= stat_q[n].overrun_flag & ~wval[1];
               stat_q[n].vld <= stat_q[n].vld & ~wval[3];
            end
            if (item_done && cur_q == 2'(n))
            begin
               len_q[n] <= cur_len - dmc_pkg::LEN_ONE;
               a_cnt_q[n] <= a_nx;
               if (cc.indirect)
                  b_cnt_q[n] <= b_nx;
               if (blk_end && (cc.auto_rl || stat_q[n].vld))
               begin
                  a_cnt_q[n] <= a_rld_q[n];
                  len_q[n] <= len_rld_q[n];
                  if (cc.indirect)
                     b_cnt_q[n] <= b_rld_q[n];
               end
               if (blk_end && cc.auto_rl)
               begin
                  if (stat_q[n].tc)
                     stat_q[n].overrun_flag <= 1'b1;
                  else
                     stat_q[n].tc <= 1'b1;
               end
               else if (blk_end && stat_q[n].vld)
               begin
                  stat_q[n].tc <= 1'b1;
                  stat_q[n].vld <= 1'b0;
               end
               else if (blk_end)
               begin
                  stat_q[n].tc <= 1'b1;
                  stat_q[n].overrun_flag <= 1'b1;
                  stat_q[n].channel_active_flag <= 1'b0;
               end
            end
            if (w_sel[n] && w_ofs == dmc_pkg::OFS_LEN_RLD)
               stat_q[n].vld <= 1'b1;
            irq[n] <= (stat_q[n].tc & ctl_q[n].tc_ie) | (stat_q[n].overrun_flag & ctl_q[n].ovr_ie);
         end
      end
   end

   default clocking dcb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_ind_rd;
      in_xf && cc.indirect;
   endsequence
   sequence s_ind_wr;
      st_q == dmc_pkg::S_WR && sys_cyc.wr && sys_cyc.drive;
   endsequence

   property p_prio;
      first && req_c[0] |=> in_xf && cur_q == 2'h0;
   endproperty
   a_prio: assert property (p_prio) else $error("channel 0 not served first");

   property p_ack;
      |ack |-> (sys_cyc.rd || sys_cyc.wr);
   endproperty
   a_ack: assert property (p_ack) else $error("acknowledge outside a bus cycle");

   property p_release;
      do_stop |=> !bus_req && st_q == dmc_pkg::S_IDLE;
   endproperty
   a_release: assert property (p_release) else $error("bus not released");

   property p_cont;
      cont_go |=> in_xf && bus_req && (sys_cyc.rd || sys_cyc.wr);
   endproperty
   a_cont: assert property (p_cont) else $error("continuous transfer broke off");

   property p_ind;
      s_ind_rd |=> s_ind_wr ##0 sys_wdata == $past(sys_rdata);
   endproperty
   a_ind: assert property (p_ind) else $error("indirect write lost held data");

   property p_len;
      item_done && !blk_end |=> len_q[$past(cur_q)] == $past(cur_len) - dmc_pkg::LEN_ONE;
   endproperty
   a_len: assert property (p_len) else $error("length counter not decremented");

   property p_single;
      blk_end && !cc.auto_rl && !stat_q[cur_q].vld |=> stat_q[$past(cur_q)] == 4'h3 || stat_q[$past(cur_q)] == 4'hB;
   endproperty
   a_single: assert property (p_single) else $error("block end flags wrong");

   property p_vld;
      wr_go && w_ofs == dmc_pkg::OFS_LEN_RLD |=> stat_q[$past(w_ch)].vld;
   endproperty
   a_vld: assert property (p_vld) else $error("valid flag not set");

   property p_reload;
      blk_end && cc.auto_rl |=> len_q[$past(cur_q)] == $past(len_rld_q[cur_q]);
   endproperty
   a_reload: assert property (p_reload) else $error("auto reload missed");
endmodule : dmc_top

// ===== test/dmc_sys_model.sv
`timescale 1ns/1ps
module dmc_sys_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic slow,
   input wire logic bus_req,
   output logic bus_grant,
   input wire dmc_pkg::dmc_sys_t sys_cyc,
   output logic [15:0] sys_rdata
);
   logic [1:0] wait_q;
   logic [1:0] wait_d;
   logic [15:0] junk_q;
   // The bus is granted at once, or two clocks after the request when slow.
   assign bus_grant = bus_req && (!slow || wait_q == 2'h2);
   assign wait_d = !bus_req ? 2'h0 : (wait_q == 2'h2 ? wait_q : wait_q + 2'h1);
   // Outside a read cycle the data lines carry junk_q, which stays at zero from reset since negating zero gives zero.
   assign sys_rdata = sys_cyc.rd ? (sys_cyc.addr[15:0] ^ 16'h5a5a) : junk_q;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wait_q <= 2'h0;
         junk_q <= 16'h0000;
      end
      else
      begin
         wait_q <= wait_d;
         junk_q <= ~junk_q + 16'h0001;
      end
   end
endmodule : dmc_sys_model

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [8:0] awaddr = 9'h000;
   logic [8:0] araddr = 9'h000;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic rq_srx = 1'b0;
   logic rq_stx = 1'b0;
   logic rq_atx = 1'b0;
   logic rq_arx = 1'b0;
   logic rq_tco = 1'b0;
   logic rq_tci = 1'b0;
   logic slow = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, bus_req, bus_grant;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata, rv;
   dmc_pkg::dmc_sys_t sys_cyc;
   logic [15:0] sys_wdata, sys_rdata;
   logic [3:0] ack, irq;
   int num_errors = 0;
   int checked = 0;
   int cyc = 0;
   logic [23:0] q_addr[$];
   logic [1:0] q_rw[$];
   logic [3:0] q_ack[$];
   logic [15:0] q_wd[$];
   int q_t[$];

   always #5 aclk = ~aclk;

   dmc_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .req_serial_rx(rq_srx), .req_serial_tx(rq_stx),
      .req_audio_rx(rq_arx), .req_transcoder_out(rq_tco), .req_audio_tx(rq_atx), .req_transcoder_in(rq_tci),
      .bus_req(bus_req), .bus_grant(bus_grant), .sys_cyc(sys_cyc), .sys_wdata(sys_wdata),
      .sys_rdata(sys_rdata), .ack(ack), .irq(irq));

   dmc_sys_model i_sys (.aclk(aclk), .aresetn(aresetn), .slow(slow), .bus_req(bus_req),
      .bus_grant(bus_grant), .sys_cyc(sys_cyc), .sys_rdata(sys_rdata));

   // Every bus cycle is logged mid-clock, where the outputs have settled, so waiting tasks see it in time.
   always @(negedge aclk)
   begin
      cyc <= cyc + 1;
      if (aresetn && (sys_cyc.rd || sys_cyc.wr))
      begin
         q_addr.push_back(sys_cyc.addr);
         q_rw.push_back({sys_cyc.rd, sys_cyc.wr});
         q_ack.push_back(ack);
         q_wd.push_back(sys_wdata);
         q_t.push_back(cyc);
      end
   end

   task automatic final_report();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wt(ref logic s);
      int n;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
      end
      while (s !== 1'b1 && n < 100);
      if (s !== 1'b1)
      begin
         num_errors++;
         final_report();
      end
   endtask : wt

   task automatic wr(input int ch, input logic [4:0] o, input logic [31:0] d);
      awaddr <= {ch[1:0], o, 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      wt(awready);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      wt(bvalid);
      bready <= 1'b0;
      chk("bresp", 32'h0000_0000, {30'h0, bresp});
      // One clock passes so that a following call does not reassign the handshake in this step.
      @(posedge aclk);
   endtask : wr

   task automatic rd(input logic [8:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      wt(arready);
      arvalid <= 1'b0;
      wt(rvalid);
      rready <= 1'b0;
      rv = rdata;
      rs = rresp;
      @(posedge aclk);
   endtask : rd

   task automatic rc(input string nm, input int ch, input logic [4:0] o, input logic [31:0] e);
      rd({ch[1:0], o, 2'b00});
      chk(nm, e, rv);
   endtask : rc

   task automatic ld(input int ch, input logic [23:0] a, input logic [23:0] b, input logic [15:0] n);
      wr(ch, dmc_pkg::OFS_A_CNT, {8'h00, a});
      wr(ch, dmc_pkg::OFS_B_CNT, {8'h00, b});
      wr(ch, dmc_pkg::OFS_LEN_CNT, {16'h0000, n});
      wr(ch, dmc_pkg::OFS_STAT, 32'h0000_000b);
   endtask : ld

   task automatic wq(input int n);
      int k;
      k = 0;
      while (q_addr.size() < n && k < 200)
      begin
         @(posedge aclk);
         k++;
      end
      if (q_addr.size() < n)
      begin
         num_errors++;
         final_report();
      end
   endtask : wq

   task automatic cb(input int i, input logic [23:0] a, input logic [1:0] rw, input logic [3:0] k);
      chk("bus addr", {8'h00, a}, {8'h00, q_addr[i]});
      chk("bus rd wr", {30'h0, rw}, {30'h0, q_rw[i]});
      chk("ack", {28'h0, k}, {28'h0, q_ack[i]});
   endtask : cb

   task automatic qclr();
      q_addr.delete();
      q_rw.delete();
      q_ack.delete();
      q_wd.delete();
      q_t.delete();
   endtask : qclr

   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rc("ctl0", 0, dmc_pkg::OFS_CTL, 32'h0000_0000);
      rc("stat3", 3, dmc_pkg::OFS_STAT, 32'h0000_0000);
      rd(9'h060);
      chk("unmapped resp", 32'h0000_0002, {30'h0, rs});
      ld(1, 24'h00_0100, 24'h00_0000, 16'h0002);
      wr(1, dmc_pkg::OFS_CTL, 32'h0000_5041);
      rq_srx <= 1'b1;
      rq_stx <= 1'b1;
      wq(2);
      rq_stx <= 1'b0;
      rq_srx <= 1'b0;
      cb(0, 24'h00_0100, 2'b10, 4'h2);
      cb(1, 24'h00_0101, 2'b10, 4'h2);
      chk("direct gap", 32'h0000_0003, 32'(q_t[1] - q_t[0]));
      rc("stat1", 1, dmc_pkg::OFS_STAT, 32'h0000_0003);
      rc("len1", 1, dmc_pkg::OFS_LEN_CNT, 32'h0000_0000);
      chk("irq", 32'h0000_0002, {28'h0, irq});
      chk("items", 32'h0000_0002, 32'(q_addr.size()));
      wr(1, dmc_pkg::OFS_A_RLD, 32'h0000_0400);
      wr(1, dmc_pkg::OFS_LEN_RLD, 32'h0000_0005);
      rc("valid set", 1, dmc_pkg::OFS_STAT, 32'h0000_000b);
      wr(1, dmc_pkg::OFS_LEN_CNT, 32'h0000_0001);
      wr(1, dmc_pkg::OFS_STAT, 32'h0000_0003);
      wr(1, dmc_pkg::OFS_CTL, 32'h0000_0000);
      wr(1, dmc_pkg::OFS_CTL, 32'h0000_5041);
      qclr();
      rq_stx <= 1'b1;
      wq(1);
      rq_stx <= 1'b0;
      cb(0, 24'h00_0102, 2'b10, 4'h2);
      rc("stat reload", 1, dmc_pkg::OFS_STAT, 32'h0000_0005);
      rc("len reload", 1, dmc_pkg::OFS_LEN_CNT, 32'h0000_0005);
      rc("addr reload", 1, dmc_pkg::OFS_A_CNT, 32'h0000_0400);
      wr(1, dmc_pkg::OFS_CTL, 32'h0000_0000);
      slow <= 1'b1;
      qclr();
      ld(0, 24'h00_0010, 24'h00_0000, 16'h0001);
      ld(3, 24'h00_0030, 24'h00_0000, 16'h0001);
      wr(0, dmc_pkg::OFS_CTL, 32'h0000_8001);
      wr(3, dmc_pkg::OFS_CTL, 32'h0000_4003);
      rq_srx <= 1'b1;
      rq_atx <= 1'b1;
      wq(2);
      rq_srx <= 1'b0;
      rq_atx <= 1'b0;
      cb(0, 24'h00_0010, 2'b10, 4'h1);
      cb(1, 24'h00_0030, 2'b01, 4'h8);
      slow <= 1'b0;
      qclr();
      ld(2, 24'h00_0200, 24'h00_0300, 16'h0002);
      wr(2, dmc_pkg::OFS_CTL, 32'h0001_01dd);
      wq(4);
      cb(0, 24'h00_0200, 2'b10, 4'h4);
      cb(1, 24'h00_0300, 2'b01, 4'h0);
      chk("held data 0", 32'h0000_585a, {16'h0000, q_wd[1]});
      cb(2, 24'h00_0202, 2'b10, 4'h4);
      cb(3, 24'h00_0301, 2'b01, 4'h0);
      chk("held data 1", 32'h0000_5858, {16'h0000, q_wd[3]});
      chk("indirect gap", 32'h0000_0002, 32'(q_t[2] - q_t[0]));
      rc("a cnt", 2, dmc_pkg::OFS_A_CNT, 32'h0000_0204);
      rc("b cnt", 2, dmc_pkg::OFS_B_CNT, 32'h0000_0302);
      // Direct continuous auto reload with a falling address and the overrun interrupt.
      wr(1, dmc_pkg::OFS_A_RLD, 32'h0000_0080);
      wr(1, dmc_pkg::OFS_LEN_RLD, 32'h0000_0002);
      ld(1, 24'h00_0050, 24'h00_0000, 16'h0002);
      wr(1, dmc_pkg::OFS_CTL, 32'h0000_6271);
      qclr();
      rq_stx <= 1'b1;
      wq(4);
      rq_stx <= 1'b0;
      cb(0, 24'h00_0050, 2'b10, 4'h2);
      cb(1, 24'h00_004f, 2'b10, 4'h2);
      cb(2, 24'h00_0080, 2'b10, 4'h2);
      cb(3, 24'h00_007f, 2'b10, 4'h2);
      chk("direct cont gap", 32'h0000_0001, 32'(q_t[1] - q_t[0]));
      chk("reload gap", 32'h0000_0003, 32'(q_t[2] - q_t[1]));
      rc("stat auto", 1, dmc_pkg::OFS_STAT, 32'h0000_0007);
      rc("len auto", 1, dmc_pkg::OFS_LEN_CNT, 32'h0000_0002);
      rc("addr auto", 1, dmc_pkg::OFS_A_CNT, 32'h0000_0080);
      chk("irq ovr", 32'h0000_0002, {28'h0, irq});
      chk("items auto", 32'h0000_0004, 32'(q_addr.size()));
      wr(1, dmc_pkg::OFS_CTL, 32'h0000_0000);
      // Secondary peripheral sources of channels 2 and 3, with the primary of channel 2 also raised.
      wr(2, dmc_pkg::OFS_CTL, 32'h0000_0000);
      wr(3, dmc_pkg::OFS_CTL, 32'h0000_0000);
      qclr();
      ld(2, 24'h00_0070, 24'h00_0000, 16'h0001);
      ld(3, 24'h00_0074, 24'h00_0000, 16'h0001);
      wr(2, dmc_pkg::OFS_CTL, 32'h0000_8001);
      wr(3, dmc_pkg::OFS_CTL, 32'h0000_8003);
      rq_arx <= 1'b1;
      rq_tco <= 1'b1;
      rq_tci <= 1'b1;
      wq(2);
      rq_arx <= 1'b0;
      rq_tco <= 1'b0;
      rq_tci <= 1'b0;
      cb(0, 24'h00_0070, 2'b10, 4'h4);
      cb(1, 24'h00_0074, 2'b01, 4'h8);
      // Indirect copy with the sense bit set: read side B, write side A.
      wr(3, dmc_pkg::OFS_CTL, 32'h0000_0000);
      qclr();
      ld(3, 24'h00_0040, 24'h00_0060, 16'h0001);
      wr(3, dmc_pkg::OFS_CTL, 32'h0001_00cb);
      wq(2);
      cb(0, 24'h00_0060, 2'b10, 4'h0);
      cb(1, 24'h00_0040, 2'b01, 4'h8);
      chk("held data 2", 32'h0000_5a3a, {16'h0000, q_wd[1]});
      rc("stat3 end", 3, dmc_pkg::OFS_STAT, 32'h0000_0003);
      rc("a cnt 3", 3, dmc_pkg::OFS_A_CNT, 32'h0000_0041);
      rc("b cnt 3", 3, dmc_pkg::OFS_B_CNT, 32'h0000_0061);
      final_report();
   end
endmodule : tb_top
